// >>> pswc_channel.sv
/*
 * push-button input channel in switching mode: debounces a contact,
 * turns edges into on/off/toggle commands on two switching objects,
 * repeats them cyclically and reacts once after the start-up delay.
 * assumes: registers reached over axi4-lite on core_clk; the telegram
 * transmitter takes one telegram per valid/ready handshake; reset_n
 * stands for bus voltage return.
 */
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "pswc_defines.svh"

module pswc_channel
    import pswc_pkg::*;
#(
    // 0.5 ms debounce base in clock cycles
    parameter int DEB_TICK_CYC  = `PSWC_CLK_HZ / 1000000 * `PSWC_DEB_BASE_US,
    // 130 ms time-base tick in clock cycles
    parameter int BASE_TICK_CYC = `PSWC_CLK_HZ / 1000 * `PSWC_TICK_MS
)
(
    input  logic          core_clk,
    input  logic          reset_n,
    input  logic          contactIn,
    input  pswc_axi_req_t axiReq,
    output pswc_axi_rsp_t axiRsp,
    output pswc_tx_t      txOut,
    input  logic          txReady
);

    // prescaler reload values
    localparam logic [12:0] DEB_RELOAD  = 13'(DEB_TICK_CYC - 1);
    localparam logic [20:0] BASE_RELOAD = 21'(BASE_TICK_CYC - 1);

    // state after reset
    localparam pswc_state_t ST_RST = '{
        ctrl:    `PSWC_CTRL_RST,
        cmd:     `PSWC_CMD_RST,
        cyc:     `PSWC_CYC_RST,
        start:   `PSWC_START_RST,
        deb:     `PSWC_DEB_RST,
        txSt:    TX_IDLE,
        tx:      '0,
        default: '0
    };

    pswc_state_t st_reg;     // present state
    pswc_state_t st_next;    // next state

    logic        debDone;    // debounce delay ran out
    logic        stDone;     // start-up delay ran out
    logic        cyc1Done;   // object one period ran out
    logic        cyc2Done;   // object two period ran out
    logic [22:0] cyc1Load;   // object one period in ticks
    logic [22:0] cyc2Load;   // object two period in ticks
    logic [22:0] stLoad;     // start-up delay in ticks

    // ****************************************************************
    // helpers
    // ****************************************************************
    // byte-lane merge of a register write
    function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction

    // {send, new value} for one command on one object
    function automatic logic [1:0] applyCmd(input pswc_cmd_t c,
                                            input logic      v);
        logic [1:0] r;
        r = {1'b0, v};
        case (c)
            CMD_NONE:   r = {1'b0, v};
            CMD_ON:     r = 2'b11;
            CMD_OFF:    r = 2'b10;
            CMD_TOGGLE: r = {1'b1, ~v};
        endcase
        return r;
    endfunction

    // repeat allowed for this mode and value
    function automatic logic repeatOk(input pswc_rep_t m, input logic v);
        logic r;
        r = 1'b0;
        case (m)
            REP_NONE: r = 1'b0;
            REP_ON:   r = v;
            REP_OFF:  r = ~v;
            REP_BOTH: r = 1'b1;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // timers
    // ****************************************************************
    // factor scaled by the power-of-two base; both cyclic periods share one factor
    assign cyc1Load = {16'h0, st_reg.cyc[`PSWC_CYC_FACT]}
                      << st_reg.cyc[`PSWC_CYC_BASE1];
    assign cyc2Load = {16'h0, st_reg.cyc[`PSWC_CYC_FACT]}
                      << st_reg.cyc[`PSWC_CYC_BASE2];
    assign stLoad   = {16'h0, st_reg.start[`PSWC_ST_FACT]}
                      << st_reg.start[`PSWC_ST_BASE];

    // debounce counts 0.5 ms ticks
    pswc_timer debTmr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .load     (st_reg.debLd),
        .loadVal  ({15'h0, st_reg.deb[`PSWC_DEB_FACT]}),
        .tick     (st_reg.debTick),
        .busy     (),
        .done     (debDone)
    );

    // start-up delay, armed once after reset
    pswc_timer stTmr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .load     (st_reg.startLd),
        .loadVal  (stLoad),
        .tick     (st_reg.baseTick),
        .busy     (),
        .done     (stDone)
    );

    // cyclic period of object one
    pswc_timer cyc1Tmr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .load     (st_reg.cycLd1),
        .loadVal  (cyc1Load),
        .tick     (st_reg.baseTick),
        .busy     (),
        .done     (cyc1Done)
    );

    // cyclic period of object two
    pswc_timer cyc2Tmr (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .load     (st_reg.cycLd2),
        .loadVal  (cyc2Load),
        .tick     (st_reg.baseTick),
        .busy     (),
        .done     (cyc2Done)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic       sw;      // channel set to switching
        logic       edgeOk;  // debounced change of level
        logic       evRise;  // act as rising edge
        logic       evFall;  // act as falling edge
        logic       off2;    // object two repeats disabled
        pswc_cmd_t  c1;      // command for object one
        pswc_cmd_t  c2;      // command for object two
        logic [1:0] r1;      // outcome on object one
        logic [1:0] r2;      // outcome on object two
        sw     = (st_reg.ctrl[`PSWC_CTRL_FUNC] == `PSWC_FUNC_SWITCH);
        edgeOk = debDone && (st_reg.sync3 != st_reg.stable);
        off2   = (st_reg.cyc[`PSWC_CYC_BASE2] == `PSWC_BASE_OFF);
        evRise = 1'b0;
        evFall = 1'b0;
        c1     = CMD_NONE;
        c2     = CMD_NONE;
        r1 = 2'h0;
        r2 = 2'h0;
        st_next = st_reg;

        // prescalers, one-cycle ticks
        st_next.debTick  = (st_reg.debPre == 13'h0);
        st_next.debPre   = st_next.debTick ? DEB_RELOAD : st_reg.debPre - 13'h1;
        st_next.baseTick = (st_reg.basePre == 21'h0);
        st_next.basePre  = st_next.baseTick ? BASE_RELOAD
                                            : st_reg.basePre - 21'h1;

        // contact synchroniser; only sync2 reads sync1
        st_next.sync1 = contactIn;
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;

        // every change restarts the debounce wait
        st_next.debLd = (st_reg.sync2 != st_reg.sync3);
        if (edgeOk)
            st_next.stable = st_reg.sync3;

        // start-up delay armed in the first cycle after reset
        st_next.started = 1'b1;
        st_next.startLd = ~st_reg.started;
        if (stDone)
            st_next.startDone = 1'b1;

        // edges count only once start-up is over
        if (sw && st_reg.startDone && edgeOk)
        begin
            evRise = st_reg.sync3;
            evFall = ~st_reg.sync3;
        end
        // input-state reaction replays the present level
        if (sw && stDone &&
            pswc_react_t'(st_reg.start[`PSWC_ST_REACT]) == REACT_INPUT)
        begin
            evRise = st_reg.stable;
            evFall = ~st_reg.stable;
        end

        // pick the commands
        if (evRise)
        begin
            c1 = pswc_cmd_t'(st_reg.cmd[`PSWC_CMD_R1]);
            c2 = pswc_cmd_t'(st_reg.cmd[`PSWC_CMD_R2]);
        end
        else if (evFall)
        begin
            c1 = pswc_cmd_t'(st_reg.cmd[`PSWC_CMD_F1]);
            c2 = pswc_cmd_t'(st_reg.cmd[`PSWC_CMD_F2]);
        end
        else if (sw && stDone)
        begin
            // fixed on/off reaction goes to object one
            case (pswc_react_t'(st_reg.start[`PSWC_ST_REACT]))
                REACT_ON:  c1 = CMD_ON;
                REACT_OFF: c1 = CMD_OFF;
                default:   c1 = CMD_NONE;
            endcase
        end

        // transmitter: launch one pending object, object one first
        unique case (st_reg.txSt)
            TX_IDLE:
            begin
                if (st_reg.pend1)
                begin
                    st_next.tx    = '{valid: 1'b1, obj: 1'b0, value: st_reg.obj1Val};
                    st_next.pend1 = 1'b0;
                    st_next.txSt  = TX_BUSY;
                end
                else if (st_reg.pend2)
                begin
                    st_next.tx    = '{valid: 1'b1, obj: 1'b1, value: st_reg.obj2Val};
                    st_next.pend2 = 1'b0;
                    st_next.txSt  = TX_BUSY;
                end
            end
            TX_BUSY:
            begin
                // hold the telegram until taken
                if (txReady)
                begin
                    st_next.tx.valid = 1'b0;
                    st_next.txSt     = TX_IDLE;
                end
            end
        endcase

        // apply commands; setting pending after the clear lets it win
        r1 = applyCmd(c1, st_reg.obj1Val);
        r2 = applyCmd(c2, st_reg.obj2Val);
        st_next.obj1Val = r1[0];
        st_next.obj2Val = r2[0];
        if (r1[1])
            st_next.pend1 = 1'b1;
        if (r2[1])
            st_next.pend2 = 1'b1;

        // cyclic repeats, value judged when the period ends
        if (sw && st_reg.startDone && cyc1Done &&
            repeatOk(pswc_rep_t'(st_reg.cyc[`PSWC_CYC_MODE]), st_reg.obj1Val))
            st_next.pend1 = 1'b1;
        if (sw && st_reg.startDone && cyc2Done && !off2 &&
            repeatOk(pswc_rep_t'(st_reg.cyc[`PSWC_CYC_MODE]), st_reg.obj2Val))
            st_next.pend2 = 1'b1;
        // an edge send restarts the period; a disabled base never runs
        st_next.cycLd1 = r1[1] | stDone | cyc1Done;
        st_next.cycLd2 = (r2[1] | stDone | cyc2Done) & ~off2;

        // axi write: response handshake, then address and data
        if (st_reg.bValid && axiReq.bready)
            st_next.bValid = 1'b0;
        if (axiReq.awvalid && st_reg.awRdy)
        begin
            st_next.awGot  = 1'b1;
            st_next.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && st_reg.wRdy)
        begin
            st_next.wGot  = 1'b1;
            st_next.wData = axiReq.wdata;
            st_next.wStrb = axiReq.wstrb;
        end
        // both halves in: commit, reserved bits kept at zero except bit 11 of start
        if (st_reg.awGot && st_reg.wGot)
        begin
            st_next.awGot  = 1'b0;
            st_next.wGot   = 1'b0;
            st_next.bValid = 1'b1;
            st_next.bResp  = `PSWC_RESP_OKAY;
            case ({st_reg.awAddr[7:2], 2'b00})
                `PSWC_ADDR_CTRL:  st_next.ctrl  = laneMerge(st_reg.ctrl,
                                      st_reg.wData, st_reg.wStrb) & `PSWC_CTRL_MASK;
                `PSWC_ADDR_CMD:   st_next.cmd   = laneMerge(st_reg.cmd,
                                      st_reg.wData, st_reg.wStrb) & `PSWC_CMD_MASK;
                `PSWC_ADDR_CYC:   st_next.cyc   = laneMerge(st_reg.cyc,
                                      st_reg.wData, st_reg.wStrb) & `PSWC_CYC_MASK;
                `PSWC_ADDR_START: st_next.start = laneMerge(st_reg.start,
                                      st_reg.wData, st_reg.wStrb) & `PSWC_START_MASK;
                `PSWC_ADDR_DEB:   st_next.deb   = laneMerge(st_reg.deb,
                                      st_reg.wData, st_reg.wStrb) & `PSWC_DEB_MASK;
                `PSWC_ADDR_STAT:  st_next.bResp = `PSWC_RESP_OKAY;    // read-only
                default:          st_next.bResp = `PSWC_RESP_SLVERR;
            endcase
        end
        // one write at a time: no new halves while a response waits
        st_next.awRdy = ~st_next.awGot & ~st_next.bValid;
        st_next.wRdy  = ~st_next.wGot & ~st_next.bValid;

        // axi read: data registered on the address handshake
        if (st_reg.rValid && axiReq.rready)
            st_next.rValid = 1'b0;
        if (axiReq.arvalid && st_reg.arRdy)
        begin
            st_next.rValid = 1'b1;
            st_next.rResp  = `PSWC_RESP_OKAY;
            case ({axiReq.araddr[7:2], 2'b00})
                `PSWC_ADDR_CTRL:  st_next.rData = st_reg.ctrl;
                `PSWC_ADDR_CMD:   st_next.rData = st_reg.cmd;
                `PSWC_ADDR_CYC:   st_next.rData = st_reg.cyc;
                `PSWC_ADDR_START: st_next.rData = st_reg.start;
                `PSWC_ADDR_DEB:   st_next.rData = st_reg.deb;
                `PSWC_ADDR_STAT:  st_next.rData = {28'h0, st_reg.startDone,
                                      st_reg.stable, st_reg.obj2Val, st_reg.obj1Val};
                default:
                begin
                    st_next.rData = 32'h0;
                    st_next.rResp = `PSWC_RESP_SLVERR;
                end
            endcase
        end
        st_next.arRdy = ~st_next.rValid;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_reg <= ST_RST;
        else
            st_reg <= st_next;
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************
    assign axiRsp = '{awready: st_reg.awRdy,  wready: st_reg.wRdy,
                      bvalid:  st_reg.bValid, bresp:  st_reg.bResp,
                      arready: st_reg.arRdy,  rvalid: st_reg.rValid,
                      rdata:   st_reg.rData,  rresp:  st_reg.rResp};
    assign txOut  = st_reg.tx;

endmodule

// >>> pswc_defines.svh
/*
 * constants of the push-button switching channel: register offsets,
 * field ranges, reset values, codes and timing figures.
 * assumes: included by bare name into each design file; no logic here.
 */
// Functional notes
// - channel function selectable, only switching acts
// - rising edge drives object one, default ON
// - falling edge drives object one, default OFF
// - rising edge drives object two, default none
// - falling edge drives object two, default none
// - toggle inverts stored object value, then sends
// - object one cyclic base one second upward; code accepts every base code, from 130 ms
// - object two cyclic base or disabled
// - one shared cyclic factor, default sixty
// - configured reaction after start-up delay
// - input-state reaction uses matching edge commands
// - inputs ignored until start-up delay elapses
// - edges accepted after debounce delay only
`ifndef PSWC_DEFINES_SVH
`define PSWC_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PSWC_ADDR_CTRL   8'h00
`define PSWC_ADDR_CMD    8'h04
`define PSWC_ADDR_CYC    8'h08
`define PSWC_ADDR_START  8'h0C
`define PSWC_ADDR_DEB    8'h10
`define PSWC_ADDR_STAT   8'h14

// ****************************************************************
// field ranges
// ****************************************************************
`define PSWC_CTRL_FUNC   2:0
`define PSWC_CMD_R1      1:0
`define PSWC_CMD_F1      3:2
`define PSWC_CMD_R2      5:4
`define PSWC_CMD_F2      7:6
`define PSWC_CYC_MODE    1:0
`define PSWC_CYC_BASE1   7:4
`define PSWC_CYC_BASE2   11:8
`define PSWC_CYC_FACT    22:16
`define PSWC_ST_BASE     3:0
`define PSWC_ST_FACT     10:4
`define PSWC_ST_REACT    13:12
`define PSWC_DEB_FACT    7:0

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define PSWC_CTRL_RST    32'h00000001
`define PSWC_CMD_RST     32'h00000009
`define PSWC_CYC_RST     32'h003C0F30
`define PSWC_START_RST   32'h00000113
`define PSWC_DEB_RST     32'h0000003C
`define PSWC_CTRL_MASK   32'h00000007
`define PSWC_CMD_MASK    32'h000000FF
`define PSWC_CYC_MASK    32'h007F0FF3
`define PSWC_START_MASK  32'h00003FFF
`define PSWC_DEB_MASK    32'h000000FF

// ****************************************************************
// codes
// ****************************************************************
`define PSWC_FUNC_SWITCH 3'h1
`define PSWC_BASE_OFF    4'hF
`define PSWC_RESP_OKAY   2'h0
`define PSWC_RESP_SLVERR 2'h2

// ****************************************************************
// timing
// ****************************************************************
`define PSWC_CLK_HZ      10000000
`define PSWC_DEB_BASE_US 500
`define PSWC_TICK_MS     130

`endif

// >>> pswc_pkg.sv
/*
 * types of the push-button switching channel: bus carriers, codes,
 * state records of the top and of the timer.
 * assumes: compiled before every module that imports it.
 */
package pswc_pkg;

    // switching command codes
    typedef enum logic [1:0] {
        CMD_NONE   = 2'h0,
        CMD_ON     = 2'h1,
        CMD_OFF    = 2'h2,
        CMD_TOGGLE = 2'h3
    } pswc_cmd_t;

    // cyclic repeat modes
    typedef enum logic [1:0] {
        REP_NONE = 2'h0,
        REP_ON   = 2'h1,
        REP_OFF  = 2'h2,
        REP_BOTH = 2'h3
    } pswc_rep_t;

    // reaction once the start-up delay has run out
    typedef enum logic [1:0] {
        REACT_NONE  = 2'h0,
        REACT_ON    = 2'h1,
        REACT_OFF   = 2'h2,
        REACT_INPUT = 2'h3
    } pswc_react_t;

    // transmit state machine, one-hot
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_BUSY = 2'b10
    } pswc_txst_t;

    // axi4-lite master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } pswc_axi_req_t;

    // axi4-lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } pswc_axi_rsp_t;

    // telegram toward the bus transmitter
    typedef struct packed {
        logic valid;
        logic obj;
        logic value;
    } pswc_tx_t;

    // countdown timer state
    typedef struct packed {
        logic [22:0] cnt;
        logic        busy;
        logic        done;
    } pswc_tmr_t;

    // complete state of the channel
    typedef struct packed {
        logic          awRdy;
        logic          wRdy;
        logic          awGot;
        logic          wGot;
        logic [7:0]    awAddr;
        logic [31:0]   wData;
        logic [3:0]    wStrb;
        logic          bValid;
        logic [1:0]    bResp;
        logic          arRdy;
        logic          rValid;
        logic [31:0]   rData;
        logic [1:0]    rResp;
        logic [31:0]   ctrl;
        logic [31:0]   cmd;
        logic [31:0]   cyc;
        logic [31:0]   start;
        logic [31:0]   deb;
        logic          sync1;
        logic          sync2;
        logic          sync3;
        logic          stable;
        logic [12:0]   debPre;
        logic          debTick;
        logic [20:0]   basePre;
        logic          baseTick;
        logic          started;
        logic          startLd;
        logic          startDone;
        logic          debLd;
        logic          cycLd1;
        logic          cycLd2;
        logic          obj1Val;
        logic          obj2Val;
        logic          pend1;
        logic          pend2;
        pswc_txst_t    txSt;
        pswc_tx_t      tx;
    } pswc_state_t;

endpackage

// >>> pswc_timer.sv
/*
 * countdown timer: loaded with a tick count, counts ticks, pulses done.
 * assumes: tick is a one-cycle pulse on core_clk; a load of zero
 * expires at once.
 */
`timescale 1ns/1ns
`include "pswc_defines.svh"

module pswc_timer
    import pswc_pkg::*;
(
    input  logic        core_clk,
    input  logic        reset_n,
    input  logic        load,
    input  logic [22:0] loadVal,
    input  logic        tick,
    output logic        busy,
    output logic        done
);

    pswc_tmr_t st_reg;    // present state
    pswc_tmr_t st_next;   // next state

    // ****************************************************************
    // next state
    // ****************************************************************
    // a reload restarts the count; the first tick may be partial,
    // so the delay runs between n-1 and n ticks
    always_comb
    begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (load)
        begin
            st_next.cnt  = loadVal;
            st_next.busy = (loadVal != 23'h0);
            st_next.done = (loadVal == 23'h0);
        end
        else if (st_reg.busy && tick)
        begin
            // last tick ends the run
            if (st_reg.cnt <= 23'h1)
            begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
            else
            begin
                st_next.cnt = st_reg.cnt - 23'h1;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign busy = st_reg.busy;
    assign done = st_reg.done;

endmodule

// >>> pswc_sink.sv
/* telegram receiver model. assumes core_clk domain, valid/ready take. */
`timescale 1ns/1ns
module pswc_sink
    import pswc_pkg::*;
(
    input  logic     core_clk,
    input  logic     reset_n,
    input  pswc_tx_t txIn,
    output logic     txReady,
    output logic     got,
    output pswc_tx_t seen
);
    // stalls one cycle per telegram so the hold is always exercised
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n)
            {txReady, got, seen} <= '0;
        else
        begin
            txReady <= txIn.valid && !txReady;
            got     <= txIn.valid && txReady;
            if (txIn.valid && txReady) seen <= txIn;
        end
endmodule

// >>> pswc_channel_sva.sv
/* port checks of pswc_channel. assumes bind below, one clock. */
`timescale 1ns/1ns
module pswc_channel_sva
    import pswc_pkg::*;
#(
    parameter int DEB_TICK_CYC  = 4,
    parameter int BASE_TICK_CYC = 16
)
(
    input logic          core_clk,
    input logic          reset_n,
    input logic          contactIn,
    input pswc_axi_req_t axiReq,
    input pswc_axi_rsp_t axiRsp,
    input pswc_tx_t      txOut,
    input logic          txReady
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic [15:0] age_reg; // cycles since release, saturating
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n) age_reg <= 16'h0000;
        else if (age_reg != 16'hFFFF) age_reg <= age_reg + 16'h0001;
    // start default: 8 ticks x 17, first tick may be partial
    a_start_quiet: assert property (txOut.valid |-> age_reg > 135 * BASE_TICK_CYC)
        else $error("early telegram");
    a_tx_hold: assert property (txOut.valid && !txReady |=> $stable(txOut))
        else $error("telegram moved");
    a_tx_gap: assert property (txOut.valid && txReady |=> !txOut.valid)
        else $error("telegram kept");
    a_rd_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
        else $error("read unanswered");
    a_rd_hold: assert property (axiRsp.rvalid && !axiReq.rready |=> $stable(axiRsp))
        else $error("read moved");
    a_ar_busy: assert property (axiRsp.rvalid |-> !axiRsp.arready)
        else $error("read overlap");
    a_wr_busy: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
        else $error("write overlap");
    a_wr_done: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
        else $error("write kept");
endmodule
bind pswc_channel pswc_channel_sva #(.DEB_TICK_CYC(DEB_TICK_CYC), .BASE_TICK_CYC(BASE_TICK_CYC))
    chk (.core_clk(core_clk), .reset_n(reset_n), .contactIn(contactIn), .axiReq(axiReq),
         .axiRsp(axiRsp), .txOut(txOut), .txReady(txReady));

// >>> tb.sv
/* channel bench. assumes pswc_sink as the telegram side. */
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
$display("unexpected %0t %h %h", $time, a, e); end end
module tb
    import pswc_pkg::*;
;
    logic          core_clk = 1'b0;
    logic          reset_n = 1'b0;
    logic          contactIn = 1'b0;
    logic          txReady, got;
    pswc_axi_req_t req = '0;
    pswc_axi_rsp_t rsp;
    pswc_tx_t      txOut, seen;
    logic [31:0]   rd;
    logic [1:0]    rs;
    int            bad_count = 0;
    int            n_checks = 0;
    always #50 core_clk = ~core_clk;
    pswc_channel #(.DEB_TICK_CYC(4), .BASE_TICK_CYC(16)) uut (.core_clk(core_clk),
        .reset_n(reset_n), .contactIn(contactIn), .axiReq(req), .axiRsp(rsp),
        .txOut(txOut), .txReady(txReady));
    pswc_sink far (.core_clk(core_clk), .reset_n(reset_n), .txIn(txOut),
        .txReady(txReady), .got(got), .seen(seen));
    task automatic close_out();
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // one access, w high for write; each channel held until taken
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        logic ta, tw, tr, fin;
        @(posedge core_clk);
        req <= '{awvalid: w, awaddr: a, wvalid: w, wdata: d, wstrb: 4'hF, bready: w,
                 arvalid: !w, araddr: a, rready: !w};
        for (i = 0; i < 99; i++)
        begin
            @(negedge core_clk);
            {ta, tw, tr, fin} = {rsp.awready, rsp.wready, rsp.arready, w ? rsp.bvalid : rsp.rvalid};
            {rd, rs} = {rsp.rdata, w ? rsp.bresp : rsp.rresp};
            @(posedge core_clk);
            if (fin) break;
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tr) req.arvalid <= 1'b0;
        end
        req <= '0;
        if (i == 99) bad_count++;
        if (i == 99) close_out();
    endtask
    // waits for one taken telegram and compares it
    task automatic tele(input logic o, input logic v);
        int i;
        for (i = 0; i < 400 && got !== 1'b1; i++) @(negedge core_clk);
        `CHK(seen, {1'b1, o, v})
        if (i == 400) bad_count++;
        if (i == 400) close_out();
        @(negedge core_clk);
    endtask
    task automatic press(input logic v);
        @(posedge core_clk);
        contactIn <= v;
    endtask
    task automatic sc_regs();
        bus(1'b0, 8'h04, 32'h0);
        `CHK(rd, 32'h00000009)
        bus(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h003C0F30)
        bus(1'b0, 8'h18, 32'h0);
        `CHK(rs, 2'h2)
        bus(1'b1, 8'h10, 32'h00000004);
        `CHK(rs, 2'h0)
    endtask
    task automatic sc_edges();
        press(1'b1);
        tele(1'b0, 1'b1);
        press(1'b0);
        tele(1'b0, 1'b0);
        bus(1'b0, 8'h14, 32'h0);
        `CHK(rd[3:0], 4'h8)
    endtask
    // pulse shorter than the debounce time: nothing sent
    task automatic sc_glitch();
        int n = 0;
        press(1'b1);
        press(1'b0);
        repeat (100) @(negedge core_clk) n += got;
        `CHK(n, 0)
    endtask
    // toggle on both objects, then off/on on falling edge
    task automatic sc_toggle();
        bus(1'b1, 8'h04, 32'h0000007B);
        press(1'b1);
        tele(1'b0, 1'b1);
        tele(1'b1, 1'b1);
        press(1'b0);
        tele(1'b0, 1'b0);
        tele(1'b1, 1'b1);
    endtask
    // repeats after a send
    task automatic sc_cyclic();
        bus(1'b1, 8'h08, 32'h00030003);
        press(1'b1);
        tele(1'b0, 1'b1);
        tele(1'b1, 1'b0);
        tele(1'b0, 1'b1);
        tele(1'b1, 1'b0);
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        sc_regs();
        repeat (2400) @(posedge core_clk);
        sc_edges();
        sc_glitch();
        sc_toggle();
        sc_cyclic();
        close_out();
    end
endmodule
